// ### dv/rps_board_model.sv
// board side: reset source, wake pin, external interrupts and slow clocks
// assumes pins idle high through pull-ups; oscillators run free
`timescale 1ns/1ns
module rps_board_model #(
  parameter int SLOW_HALF_NS = 300
) (
  // system clock
  input wire logic clock,
  // pins toward the controller
  output logic resetPinN,
  output logic wakeRequestPinN,
  output logic [1:0] externalInterruptN,
  output logic externalInputClock,
  output logic slowRtcClock
);
  initial begin
    resetPinN = 1'b1;
    wakeRequestPinN = 1'b1;
    externalInterruptN = 2'h3;
    externalInputClock = 1'b0;
    slowRtcClock = 1'b0;
  end
  // shortened rtc period; its rising edges land on system clock rising edges
  always #(SLOW_HALF_NS) slowRtcClock = ~slowRtcClock;
  always #(SLOW_HALF_NS / 3 + 7) externalInputClock = ~externalInputClock;
  // one low pulse; 0 reset, 1 wake, 2 and 3 interrupts; the width is the caller's, not checked against any minimum here
  task automatic lowPulse(input int pin, input int cyc);
    @(posedge clock);
    case (pin)
      0: resetPinN <= 1'b0;
      1: wakeRequestPinN <= 1'b0;
      default: externalInterruptN[pin-2] <= 1'b0;
    endcase
    repeat (cyc) @(posedge clock);
    resetPinN <= 1'b1;
    wakeRequestPinN <= 1'b1;
    externalInterruptN <= 2'h3;
  endtask
endmodule

// ### dv/rps_reset_wake_monitor.sv
// concurrent checks on the reset and wake controller ports
// assumes one system clock and sys_rst as the only reset; attached by bind
`timescale 1ns/1ns
module rps_reset_wake_monitor #(
  parameter int NINT = 8
) (
  // clock and reset
  input wire logic clock,
  input wire logic sys_rst,
  // watched inputs
  input wire logic resetPinN,
  input wire logic busSelectGpio,
  input wire logic [rps_pkg::ADDR_MUX_W-1:0] gpioAddrHigh,
  input wire rps_pkg::rps_pins_t periphPins,
  // watched outputs
  input wire logic hwResetActive,
  input wire logic sysclkGenEnable,
  input wire logic pllBypass,
  input wire logic bootStart,
  input wire logic cpuRunning,
  input wire logic [NINT+2:0] intRequest,
  input wire rps_pkg::rps_pins_t padPins
);
  default clocking @(posedge clock); endclocking
  default disable iff (sys_rst);
  rps_pkg::rps_pins_t passPins;
  logic rstPrevR;
  logic lightR;
  logic inRst;
  // pads only settle one edge after the reset state is seen
  assign inRst = hwResetActive && rstPrevR;
  // expected pad record outside reset, address bits muxed by the bus select
  always_comb begin
    passPins = periphPins;
    if (busSelectGpio) begin
      passPins.synX0[rps_pkg::ADDR_MUX_LSB +: rps_pkg::ADDR_MUX_W] = gpioAddrHigh;
    end
  end
  // history of the reset status; cleared by power-on so its release edge is skipped
  always_ff @(posedge clock or posedge sys_rst) begin
    if (sys_rst) begin
      rstPrevR <= 1'b0;
    end else begin
      rstPrevR <= hwResetActive;
    end
  end
  // light idle tracker: the cpu stopped without the clock generator bypass
  always_ff @(posedge clock or posedge sys_rst) begin
    if (sys_rst) begin
      lightR <= 1'b0;
    end else if (cpuRunning || hwResetActive) begin
      lightR <= 1'b0;
    end else if ($fell(cpuRunning) && !pllBypass) begin
      lightR <= 1'b1;
    end
  end
  high_group_a: assert property (inRst |-> padPins.high == '1)
    else $error("high group not high in reset");
  low_group_a: assert property (inRst |-> padPins.low == '0)
    else $error("low group not low in reset");
  z_group_a: assert property (inRst |-> padPins.zOe == '0)
    else $error("float group driven in reset");
  sync_groups_a: assert property (inRst |-> padPins.syn01 == '1 && padPins.syn10 == '0)
    else $error("sync groups wrong in reset");
  settle_groups_a: assert property (inRst |-> padPins.synX1 == '1 && padPins.synX0 == '0)
    else $error("settle groups wrong in reset");
  pin_pass_a: assert property (!hwResetActive && !rstPrevR |->
      {padPins[144:30], padPins[28:0]} == $past({passPins[144:30], passPins[28:0]}))
    else $error("pads do not follow peripherals");
  boot_order_a: assert property (bootStart |-> sysclkGenEnable ##1 (cpuRunning && !bootStart))
    else $error("boot start out of order");
  reset_width_a: assert property ($rose(hwResetActive) |-> !$past(resetPinN, 3))
    else $error("reset taken from a short pulse");
  light_wake_a: assert property (lightR && (|intRequest) |-> ##[1:5] cpuRunning)
    else $error("light idle did not resume");
  deep_bypass_a: assert property (pllBypass |-> !sysclkGenEnable && !cpuRunning)
    else $error("clock generator on in deep idle");
endmodule

bind rps_reset_wake_ctl rps_reset_wake_monitor #(.NINT(NINT)) u_rps_reset_wake_monitor (.*);

// ### dv/rps_testbench.sv
// self-checking bench for the reset and wake controller
// assumes the board model drives reset, wake and interrupt pins
`timescale 1ns/1ns
module testbench;
  localparam int NINT = 8;
  logic clock = 1'b0;
  logic sys_rst = 1'b1;
  logic resetPinN, wakeRequestPinN, externalInputClock, slowRtcClock;
  logic [1:0] externalInterruptN;
  logic [1:0] clockOutSel = 2'h0;
  logic rtcInterrupt = 1'b0, enterLightIdle = 1'b0, enterDeepIdle = 1'b0, sysclkDisableFlag = 1'b0;
  logic clockSourceSel = 1'b0, softResetReq = 1'b0, busSelectGpio = 1'b0, bootSeen = 1'b0;
  logic cpuClockLevel = 1'b1, usbPhyClockLevel = 1'b0, pllClockLevel = 1'b0;
  logic [NINT-1:0] intSource = '0;
  logic [NINT+2:0] intEnable = '0, intAck = '0, intPending, intRequest;
  logic [5:0] gpioAddrHigh = 6'h2D;
  rps_pkg::rps_pins_t periphPins = '0, padPins, expPins;
  logic hwResetActive, sysclkGenEnable, pllBypass, sysclkFromRtc, bootStart, cpuRunning, cpuSoftReset;
  int failures = 0, check_count = 0;
  // shortened qualifier and settle counts keep the run brief
  rps_reset_wake_ctl #(.NINT(NINT), .WAKE_LOW_CYC(8), .CLKGEN_CYC(4)) u_rps_reset_wake_ctl (.*);
  rps_board_model u_rps_board_model (.*);
  always #20 clock = ~clock;
  always @(posedge clock) if (bootStart === 1'b1) bootSeen <= 1'b1;
  task automatic chk(input string nm, input logic [159:0] got, input logic [159:0] exp);
    check_count++;
    if (got !== exp) begin
      failures++;
      $display("wrong value %s expected %0h seen %0h", nm, exp, got);
    end
  endtask
  task automatic end_sim();
    $display("checks %0d failures %0d", check_count, failures);
    if (failures == 0 && check_count > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask
  // bounded wait on the run status; a hang ends the run
  task automatic waitRun(input logic want, input int lim);
    int n;
    n = 0;
    while (cpuRunning !== want && n < lim) begin
      @(negedge clock);
      n++;
    end
    chk("cpuRunning", cpuRunning, want);
    if (cpuRunning !== want) end_sim();
  endtask
  // clear pending flags, set enables, then request an idle mode
  task automatic sleep(input logic deep, input logic [NINT+2:0] en);
    @(posedge clock);
    intAck <= '1;
    intEnable <= en;
    @(posedge clock);
    intAck <= '0;
    enterDeepIdle <= deep;
    enterLightIdle <= !deep;
    @(posedge clock);
    enterDeepIdle <= 1'b0;
    enterLightIdle <= 1'b0;
    waitRun(1'b0, 4);
  endtask
  initial begin
    repeat (10) @(posedge clock);
    chk("hwResetActive", hwResetActive, 1'b1);
    sys_rst <= 1'h0;
    waitRun(1'h1, 60);
    chk("bootSeen", bootSeen, 1'b1);
    chk("sysclkGenEnable", sysclkGenEnable, 1'b1);
    // pass-through with and without the address mux
    for (int g = 0; g < 2; g++) begin
      @(posedge clock);
      periphPins <= {5{29'h15A5C3E1}} ^ {145{g[0]}};
      busSelectGpio <= g[0];
      repeat (2) @(posedge clock);
      @(negedge clock);
      expPins = periphPins;
      if (g == 1) expPins.synX0[20:15] = gpioAddrHigh;
      chk("padPins", {padPins[144:30], padPins[28:0]}, {expPins[144:30], expPins[28:0]});
    end
    // each monitor code shows its selected source high while the other sources are low
    for (int s = 0; s < 4; s++) begin
      @(posedge clock);
      clockOutSel <= s[1:0];
      {cpuClockLevel, usbPhyClockLevel, pllClockLevel} <= (s == 1) ? 3'h2 : (s == 2) ? 3'h1 : 3'h4;
      repeat (3) @(posedge clock);
      @(negedge clock);
      chk("clkGrp0", padPins.clkGrp[0], 1'b1);
    end
    u_rps_board_model.lowPulse(0, 9);
    @(negedge clock);
    expPins = '0;
    expPins.high = '1;
    expPins.syn01 = '1;
    expPins.synX1 = '1;
    expPins.clkGrp = 2'h3;
    chk("resetPins", padPins, expPins);
    waitRun(1'b1, 60);
    @(posedge clock);
    softResetReq <= 1'b1;
    repeat (2) @(posedge clock);
    @(negedge clock);
    chk("cpuSoftReset", cpuSoftReset, 1'b1);
    chk("hwResetActive", hwResetActive, 1'b0);
    @(posedge clock);
    softResetReq <= 1'b0;
    // masked interrupt leaves light idle alone until enabled
    sleep(1'b0, '0);
    @(posedge clock);
    intSource <= 8'h01;
    @(posedge clock);
    intSource <= '0;
    repeat (8) @(posedge clock);
    @(negedge clock);
    chk("cpuRunning", cpuRunning, 1'b0);
    chk("intPending", intPending[0], 1'h1);
    chk("intRequest", intRequest, 11'h000);
    @(posedge clock);
    intEnable <= 11'h001;
    waitRun(1'b1, 8);
    sleep(1'b0, 11'h100);
    u_rps_board_model.lowPulse(2, 3);
    waitRun(1'h1, 12);
    sleep(1'b0, 11'h400);
    @(posedge clock);
    rtcInterrupt <= 1'b1;
    waitRun(1'h1, 12);
    @(posedge clock);
    rtcInterrupt <= 1'h0;
    // deep idle with the clock running: a short external interrupt edge wakes
    sleep(1'h1, 11'h100);
    u_rps_board_model.lowPulse(2, 3);
    waitRun(1'h1, 100);
    // deep idle from the rtc clock, woken by the wake pin
    @(posedge clock);
    sysclkDisableFlag <= 1'h1;
    sleep(1'h1, '0);
    chk("pllBypass", pllBypass, 1'h1);
    chk("sysclkFromRtc", sysclkFromRtc, 1'h1);
    // a wake glitch shorter than the qualifier must not wake the part
    u_rps_board_model.lowPulse(1, 3);
    repeat (12) @(posedge clock);
    @(negedge clock);
    chk("cpuRunning", cpuRunning, 1'h0);
    u_rps_board_model.lowPulse(1, 12);
    waitRun(1'h1, 100);
    @(posedge clock);
    clockSourceSel <= 1'h1;
    sleep(1'h1, 11'h200);
    chk("sysclkFromRtc", sysclkFromRtc, 1'h0);
    u_rps_board_model.lowPulse(3, 12);
    waitRun(1'b1, 100);
    end_sim();
  end
endmodule

// ### logic/rps_pkg.sv
// shared constants, pin-group layout and state type for the reset and wake controller
// assumes one 25 MHz system clock; all counts below are in cycles of that clock
package rps_pkg;

  // clock period and timing figures
  localparam int unsigned CLK_PERIOD_NS = 40;
  localparam logic [1:0] RESET_MIN_CYC = 2'h3;     // reset pin low, in system clock periods
  localparam int unsigned INT_PHASE_MIN_CYC = 2;   // interrupt high/low phase while active
  localparam int unsigned WAKE_LOW_MIN_NS = 30500; // wake or interrupt low, clock disabled
  localparam int unsigned WAKE_LOW_MIN_CYC = (WAKE_LOW_MIN_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam logic [7:0] LIGHT_WAKE_CYC = 8'h03;   // light idle resume latency
  localparam int unsigned CLKGEN_LOCK_CYC = 16;    // clock generator settle before boot
  localparam int unsigned QW = 10;                 // width of the low-pulse qualifiers
  localparam int unsigned CW = 8;                  // width of the state counter

  // pin group widths
  localparam int unsigned HIGH_W = 11;
  localparam int unsigned LOW_W = 5;
  localparam int unsigned Z_W = 49;
  localparam int unsigned SYN01_W = 3;
  localparam int unsigned SYN10_W = 2;
  localparam int unsigned SYNX1_W = 3;
  localparam int unsigned SYNX0_W = 21;
  localparam int unsigned ADDR_MUX_LSB = 15;
  localparam int unsigned ADDR_MUX_W = 6;

  // synchroniser bit positions and idle values
  localparam int unsigned SY_W = 7;
  localparam int unsigned SY_RST = 0;
  localparam int unsigned SY_WAKE = 1;
  localparam int unsigned SY_EXT0 = 2;
  localparam int unsigned SY_RTCINT = 4;
  localparam int unsigned SY_EXTCLK = 5;
  localparam int unsigned SY_SLOW_RTC_CLOCK = 6;
  localparam logic [SY_W-1:0] SY_RST_VAL = 7'h0F;

  // clock monitor source codes
  localparam logic [1:0] CLKO_CPU = 2'h0;
  localparam logic [1:0] CLKO_USB = 2'h1;
  localparam logic [1:0] CLKO_PLL = 2'h2;

  // one record for every controlled output pin, value and enable
  typedef struct packed {
    logic [HIGH_W-1:0] high;
    logic [LOW_W-1:0] low;
    logic [Z_W-1:0] zOut;
    logic [Z_W-1:0] zOe;
    logic [1:0] clkGrp;
    logic [SYN01_W-1:0] syn01;
    logic [SYN10_W-1:0] syn10;
    logic [SYNX1_W-1:0] synX1;
    logic [SYNX0_W-1:0] synX0;
  } rps_pins_t;

  typedef enum logic [2:0] {
    ST_RESET, ST_CLKGEN, ST_BOOT, ST_ACTIVE,
    ST_LIGHT_IDLE, ST_LIGHT_WAKE, ST_DEEP_IDLE, ST_DEEP_WAKE
  } rps_state_t;

endpackage

// ### logic/rps_reset_wake_ctl.sv
// reset pin handling, output pin reset states, interrupt capture and idle wake-up
// assumes the peripherals drive the pin record on the same clock; pins and slow
// clocks arrive asynchronously and are synchronised here
//
// Function
// - pin reset fully resets the block; software reset never enters that path.
// - after reset, enable clock generator, then start the boot sequence.
// - outside reset, shared pins follow the peripheral the bus select assigns.
// - in reset drive chip selects, byte masks, strobes and serial select three high.
// - in reset drive serial clock, read/write, card clocks and SDRAM clock low.
// - in reset float data bus, emulation, I2C, serial data, muxed, RTC, TDO, wake.
// - in reset clock output and serial select one follow the clock monitor.
// - serial selects 0,2 and clock enable go 0 to 1; SDRAM selects 1 to 0.
// - bank address and flag settle high; address bits settle low, both synchronously.
// - deep idle bypasses the clock generator; clock from input or RTC per select.
// - every interrupt has its own enable.
// - deep idle resumes after one input clock or one RTC clock period.
// - light idle resumes three clock periods after an external interrupt.
// - external interrupts wake only from deep and light idle.
// - RTC interrupt wakes from deep and light idle.
// - any unmasked interrupt ends light idle.
// - clock output shows CPU, USB PHY or PLL clock per selection.
`timescale 1ns/1ns

module rps_reset_wake_ctl #(
  parameter int NINT = 8,
  parameter int WAKE_LOW_CYC = rps_pkg::WAKE_LOW_MIN_CYC,
  parameter int CLKGEN_CYC = rps_pkg::CLKGEN_LOCK_CYC
) (
  // clock and power-on reset
  input wire logic clock,
  input wire logic sys_rst,
  // asynchronous pins and slow clocks
  input wire logic resetPinN,
  input wire logic wakeRequestPinN,
  input wire logic [1:0] externalInterruptN,
  input wire logic rtcInterrupt,
  input wire logic externalInputClock,
  input wire logic slowRtcClock,
  // idle control
  input wire logic enterLightIdle,
  input wire logic enterDeepIdle,
  input wire logic sysclkDisableFlag,
  input wire logic clockSourceSel,
  input wire logic softResetReq,
  // interrupt control
  input wire logic [NINT-1:0] intSource,
  input wire logic [NINT+2:0] intEnable,
  input wire logic [NINT+2:0] intAck,
  // clock monitor sources and selection
  input wire logic cpuClockLevel,
  input wire logic usbPhyClockLevel,
  input wire logic pllClockLevel,
  input wire logic [1:0] clockOutSel,
  // peripheral side of the pins
  input wire rps_pkg::rps_pins_t periphPins,
  input wire logic [rps_pkg::ADDR_MUX_W-1:0] gpioAddrHigh,
  input wire logic busSelectGpio,
  // status
  output logic hwResetActive,
  output logic sysclkGenEnable,
  output logic pllBypass,
  output logic sysclkFromRtc,
  output logic bootStart,
  output logic cpuRunning,
  output logic cpuSoftReset,
  output logic [NINT+2:0] intPending,
  output logic [NINT+2:0] intRequest,
  // pad side
  output rps_pkg::rps_pins_t padPins
);

  localparam int TOT = NINT + 3;
  localparam int NQ = 3; // wake pin plus the two external interrupts

  logic [rps_pkg::SY_W-1:0] syncA_r, syncB_r, syncC_r;
  logic [1:0] rstLowCnt_r;
  logic hwRecognised;
  logic [rps_pkg::QW-1:0] lowCnt_r [0:NQ-1];
  logic [NQ-1:0] qualHit;
  logic [1:0] extFall;
  logic [1:0] extEvt;
  logic wakeFall, wakePinEvt, rtcRise, extClkTick, rtcClkTick, slowTick;
  logic [TOT-1:0] intEvent;
  logic [TOT-1:0] pending_r;
  logic lightWake, deepWake, deepIdle, deepNext, pinReset;
  rps_pkg::rps_state_t state_r, state_nxt;
  logic [rps_pkg::CW-1:0] cnt_r;
  logic clock_monitor_out_r;
  rps_pkg::rps_pins_t padMain_r;
  logic [rps_pkg::SYNX1_W-1:0] padX1_r;
  logic [rps_pkg::SYNX0_W-1:0] padX0_r;

  // two-stage synchroniser; the third stage only serves edge detection
  always_ff @(posedge clock or posedge sys_rst) begin
    if (sys_rst) begin
      syncA_r <= rps_pkg::SY_RST_VAL;
      syncB_r <= rps_pkg::SY_RST_VAL;
      syncC_r <= rps_pkg::SY_RST_VAL;
    end else begin
      syncA_r <= {slowRtcClock, externalInputClock, rtcInterrupt, externalInterruptN, wakeRequestPinN, resetPinN};
      syncB_r <= syncA_r;
      syncC_r <= syncB_r;
    end
  end

  // edges seen on synchronised levels
  assign extFall = ~syncB_r[rps_pkg::SY_EXT0 +: 2] & syncC_r[rps_pkg::SY_EXT0 +: 2];
  assign wakeFall = ~syncB_r[rps_pkg::SY_WAKE] & syncC_r[rps_pkg::SY_WAKE];
  assign rtcRise = syncB_r[rps_pkg::SY_RTCINT] & ~syncC_r[rps_pkg::SY_RTCINT];
  assign extClkTick = syncB_r[rps_pkg::SY_EXTCLK] & ~syncC_r[rps_pkg::SY_EXTCLK];
  assign rtcClkTick = syncB_r[rps_pkg::SY_SLOW_RTC_CLOCK] & ~syncC_r[rps_pkg::SY_SLOW_RTC_CLOCK];

  // reset pin must stay low three samples; shorter glitches are dropped
  always_ff @(posedge clock or posedge sys_rst) begin
    if (sys_rst) begin
      rstLowCnt_r <= 2'h0;
    end else if (syncB_r[rps_pkg::SY_RST]) begin
      rstLowCnt_r <= 2'h0;
    end else if (rstLowCnt_r != rps_pkg::RESET_MIN_CYC) begin
      rstLowCnt_r <= rstLowCnt_r + 2'h1;
    end
  end
  assign hwRecognised = (rstLowCnt_r == rps_pkg::RESET_MIN_CYC);

  // low-pulse qualifiers for wake pin and both external interrupts
  genvar gi;
  generate
    for (gi = 0; gi < NQ; gi++) begin : gQual
      always_ff @(posedge clock or posedge sys_rst) begin
        if (sys_rst) begin
          lowCnt_r[gi] <= '0;
        end else if (syncB_r[rps_pkg::SY_WAKE + gi]) begin
          lowCnt_r[gi] <= '0;
        end else if (lowCnt_r[gi] != rps_pkg::QW'(WAKE_LOW_CYC)) begin
          lowCnt_r[gi] <= lowCnt_r[gi] + 1'h1;
        end
      end
      // fires once, on the cycle the low time is reached
      assign qualHit[gi] = ~syncB_r[rps_pkg::SY_WAKE + gi] &&
                           (lowCnt_r[gi] == rps_pkg::QW'(WAKE_LOW_CYC - 1));
    end
  endgenerate

  // with the clock disabled a glitch must not wake the part, so the long low is required
  assign deepIdle = (state_r == rps_pkg::ST_DEEP_IDLE) || (state_r == rps_pkg::ST_DEEP_WAKE);
  assign extEvt = (deepIdle && sysclkDisableFlag) ? qualHit[2:1] : extFall;
  assign wakePinEvt = sysclkDisableFlag ? qualHit[0] : wakeFall;
  assign intEvent = {rtcRise, extEvt, intSource};

  // sticky pending flags; a new event outweighs an acknowledge in the same cycle
  always_ff @(posedge clock or posedge sys_rst) begin
    if (sys_rst) begin
      pending_r <= '0;
    end else if (pinReset) begin
      pending_r <= '0;
    end else begin
      pending_r <= (pending_r & ~intAck) | intEvent;
    end
  end
  assign intPending = pending_r;
  assign intRequest = pending_r & intEnable;

  // wake qualification per idle mode
  assign lightWake = |(pending_r & intEnable);
  assign deepWake = wakePinEvt || |(pending_r[TOT-1:NINT] & intEnable[TOT-1:NINT]);
  assign slowTick = clockSourceSel ? extClkTick : rtcClkTick;
  assign pinReset = (state_r == rps_pkg::ST_RESET);

  // sequencer next state; a recognised pin reset overrides everything
  always_comb begin
    state_nxt = state_r;
    unique case (state_r)
      rps_pkg::ST_RESET: begin
        if (!hwRecognised) begin
          state_nxt = rps_pkg::ST_CLKGEN;
        end
      end
      rps_pkg::ST_CLKGEN: begin
        if (cnt_r == rps_pkg::CW'(CLKGEN_CYC - 1)) begin
          state_nxt = rps_pkg::ST_BOOT;
        end
      end
      rps_pkg::ST_BOOT: begin
        state_nxt = rps_pkg::ST_ACTIVE;
      end
      rps_pkg::ST_ACTIVE: begin
        if (enterDeepIdle) begin
          state_nxt = rps_pkg::ST_DEEP_IDLE;
        end else if (enterLightIdle) begin
          state_nxt = rps_pkg::ST_LIGHT_IDLE;
        end
      end
      rps_pkg::ST_LIGHT_IDLE: begin
        if (lightWake) begin
          state_nxt = rps_pkg::ST_LIGHT_WAKE;
        end
      end
      rps_pkg::ST_LIGHT_WAKE: begin
        if (cnt_r == rps_pkg::LIGHT_WAKE_CYC - 8'h01) begin
          state_nxt = rps_pkg::ST_ACTIVE;
        end
      end
      rps_pkg::ST_DEEP_IDLE: begin
        if (deepWake) begin
          state_nxt = rps_pkg::ST_DEEP_WAKE;
        end
      end
      rps_pkg::ST_DEEP_WAKE: begin
        if (slowTick) begin
          state_nxt = rps_pkg::ST_ACTIVE;
        end
      end
    endcase
    if (hwRecognised) begin
      state_nxt = rps_pkg::ST_RESET;
    end
  end

  // state register
  always_ff @(posedge clock or posedge sys_rst) begin
    if (sys_rst) begin
      state_r <= rps_pkg::ST_RESET;
    end else begin
      state_r <= state_nxt;
    end
  end

  // cycle counter restarts on every state change
  always_ff @(posedge clock or posedge sys_rst) begin
    if (sys_rst) begin
      cnt_r <= '0;
    end else if (state_nxt != state_r) begin
      cnt_r <= '0;
    end else if (cnt_r != '1) begin
      cnt_r <= cnt_r + 1'h1;
    end
  end

  // deep idle as seen by the next state, shared by the clock controls
  assign deepNext = (state_nxt == rps_pkg::ST_DEEP_IDLE) || (state_nxt == rps_pkg::ST_DEEP_WAKE);

  // reset and boot status, decoded from the next state so it lines up with state_r
  always_ff @(posedge clock or posedge sys_rst) begin
    if (sys_rst) begin
      hwResetActive <= 1'h1;
      bootStart <= 1'h0;
    end else begin
      hwResetActive <= (state_nxt == rps_pkg::ST_RESET);
      bootStart <= (state_nxt == rps_pkg::ST_BOOT);
    end
  end

  // clock generator control; stays off until the sequencer leaves reset
  always_ff @(posedge clock or posedge sys_rst) begin
    if (sys_rst) begin
      sysclkGenEnable <= 1'h0;
      pllBypass <= 1'h0;
      sysclkFromRtc <= 1'h0;
    end else begin
      sysclkGenEnable <= (state_nxt != rps_pkg::ST_RESET) && !deepNext;
      pllBypass <= deepNext;
      sysclkFromRtc <= deepNext && !clockSourceSel;
    end
  end

  // cpu run status, low through every idle and wake latency
  always_ff @(posedge clock or posedge sys_rst) begin
    if (sys_rst) begin
      cpuRunning <= 1'h0;
    end else begin
      cpuRunning <= (state_nxt == rps_pkg::ST_ACTIVE);
    end
  end

  // software reset is only passed on; it never touches the sequencer
  always_ff @(posedge clock or posedge sys_rst) begin
    if (sys_rst) begin
      cpuSoftReset <= 1'h0;
    end else begin
      cpuSoftReset <= softResetReq && !pinReset;
    end
  end

  // clock monitor; code 3 is unused and falls back to the cpu clock
  always_ff @(posedge clock or posedge sys_rst) begin
    if (sys_rst) begin
      clock_monitor_out_r <= 1'h0;
    end else begin
      case (clockOutSel)
        rps_pkg::CLKO_CPU: clock_monitor_out_r <= cpuClockLevel;
        rps_pkg::CLKO_USB: clock_monitor_out_r <= usbPhyClockLevel;
        rps_pkg::CLKO_PLL: clock_monitor_out_r <= pllClockLevel;
        default: clock_monitor_out_r <= cpuClockLevel;
      endcase
    end
  end

  // pins with a defined reset level; sync groups take their final level one edge in
  always_ff @(posedge clock or posedge sys_rst) begin
    if (sys_rst) begin
      padMain_r <= '0;
      padMain_r.high <= '1;
      padMain_r.syn10 <= '1;
      padMain_r.zOe <= '0;
    end else if (pinReset) begin
      padMain_r <= '0;
      padMain_r.high <= '1;
      padMain_r.low <= '0;
      padMain_r.zOe <= '0;
      padMain_r.zOut <= '0;
      padMain_r.syn01 <= '1;
      padMain_r.syn10 <= '0;
      padMain_r.clkGrp <= {clock_monitor_out_r, clock_monitor_out_r};
    end else begin
      padMain_r <= periphPins;
      padMain_r.clkGrp <= {periphPins.clkGrp[1], clock_monitor_out_r};
    end
  end

  // bank address and flag have no reset value: unknown until the first edge in reset
  always_ff @(posedge clock) begin
    if (pinReset) begin
      padX1_r <= '1;
    end else begin
      padX1_r <= periphPins.synX1;
    end
  end

  // address bits likewise; the top six follow the gpio side when the bus select says so
  always_ff @(posedge clock) begin
    if (pinReset) begin
      padX0_r <= '0;
    end else begin
      padX0_r <= {busSelectGpio ? gpioAddrHigh : periphPins.synX0[rps_pkg::ADDR_MUX_LSB +: rps_pkg::ADDR_MUX_W],
                  periphPins.synX0[rps_pkg::ADDR_MUX_LSB-1:0]};
    end
  end

  // pad record assembly
  always_comb begin
    padPins = padMain_r;
    padPins.synX1 = padX1_r;
    padPins.synX0 = padX0_r;
  end

endmodule
